// [include/ncd_pkg.sv]
// Package of constants, types and opcodes for the nibble core datapath
package ncd_pkg;
  // Widths
  localparam int NIB_W = 4;
  localparam int PC_W = 14;
  localparam int PAGE_LO = 7;
  localparam int PTR_W = 3;
  localparam int SP_W = 3;
  localparam int STACK_DEPTH = 8;
  localparam int ZW = 2;
  localparam int XW = 3;
  localparam int YW = 4;
  localparam int PORTD_W = 10;
  // Instruction clock divider
  localparam int ICLK_DIV = 3;
  localparam logic [1:0] DIV_LAST = 2'(ICLK_DIV - 1);
  localparam logic [6:0] IN_PAGE_LAST = 7'h7F;
  // Reset values
  localparam logic [PC_W-1:0] PC_RST = 14'h0000;
  localparam logic [3:0] NIB_RST = 4'h0;
  // Operation codes presented on the operation port
  typedef enum logic [4:0] {
    OP_NOP, OP_ADD_IMM, OP_ADD_MEM, OP_ADD_WITH_CARRY, OP_CMP_MEM, OP_AND_MEM, OP_OR_MEM,
    OP_BIT_SET, OP_BIT_CLR, OP_BIT_TEST, OP_ROTATE_RIGHT, OP_CARRY_SET, OP_CARRY_CLR,
    OP_LOAD_A, OP_LOAD_B, OP_PAIR_TO_E, OP_E_TO_PAIR, OP_LOAD_PTR, OP_LOAD_PTR_Z,
    OP_LOAD_PTR_X, OP_LOAD_PTR_Y, OP_STACK_INDEX_READ, OP_TABLE_LOOKUP, OP_INDEXED_JUMP,
    OP_INDEXED_CALL, OP_JUMP, OP_CALL, OP_RETURN, OP_INT_ENTRY, OP_INT_RETURN,
    OP_PORT_BIT_SET, OP_PORT_BIT_CLR
  } ncd_op_t;
  // One instruction as the decoder hands it over
  typedef struct packed {
    ncd_op_t op;
    logic [3:0] imm;
    logic [1:0] bit_sel;
    logic [PC_W-1:0] target;
  } ncd_instr_t;
  // Interrupt save stage contents
  typedef struct packed {
    logic [ZW-1:0] z;
    logic [XW-1:0] x;
    logic [YW-1:0] y;
    logic carry;
    logic skip;
    logic [3:0] a;
    logic [3:0] b;
  } ncd_save_t;
endpackage : ncd_pkg

// [core/ncd_core.sv]
// Nibble CPU core datapath: ALU, flags, pointers, stack, program counter
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// What this block does
// - 4-bit ALU adds, compares, ANDs, ORs, bit-ops
// - Add-with-carry sets carry on carry out
// - Plain adds leave carry flag unchanged
// - Rotate right copies accumulator bit0 to carry
// - Dedicated ops set or clear carry
// - Eight-bit register copies to and from B:A pair
// - Pointer:A forms 7-bit in-page ROM address
// - Eight return registers, pushed on call/interrupt, top slot borrowed by lookup
// - Overflow past eight wraps silently, no flag
// - Stack index tracks depth, readable into A
// - Interrupt entry saves RAM pointer, flags, A, B
// - Save stage used only by interrupt entry/return
// - Skip flag decides skips, saved across interrupts
// - Counter advances, or loads target on branches
// - Counter splits into page and in-page fields
// - In-page 127 wraps to 0, page increments
// - RAM pointer is group, file, digit selectors
// - Digit selector picks port D bit
// - Instruction clock is system clock divided by three
module ncd_core #(
  parameter int PC_WIDTH = ncd_pkg::PC_W
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Instruction from decoder, taken on an instruction clock tick
  input wire ncd_pkg::ncd_instr_t INSTR,
  // Program ROM data word for table lookup
  input wire logic [9:0] ROM_DATA,
  // Data RAM read nibble at the current pointer
  input wire logic [3:0] RAM_RDATA,
  // Skip condition raised by an external test (flag tests)
  input wire logic SKIP_REQ,
  // Interrupt vector for entry
  input wire logic [PC_WIDTH-1:0] INT_VECTOR,
  // Program address out
  output logic [PC_WIDTH-1:0] PC,
  output logic [6:0] TABLE_ADDR,
  // RAM address and write
  output logic [ncd_pkg::ZW-1:0] RAM_Z,
  output logic [ncd_pkg::XW-1:0] RAM_X,
  output logic [ncd_pkg::YW-1:0] RAM_Y,
  output logic [3:0] RAM_WDATA,
  output logic RAM_WE,
  // Visible state
  output logic [3:0] ACC,
  output logic [3:0] REG_B,
  output logic [7:0] REG_E,
  output logic CARRY_FLAG,
  output logic SKIP_FLAG,
  output logic [ncd_pkg::SP_W-1:0] STACK_INDEX,
  output logic INSTR_TICK,
  // Port D output latches
  output logic [ncd_pkg::PORTD_W-1:0] PORT_D
);
  // Divider state and tick
  logic [1:0] div_q;
  logic tick_q;
  // Working registers
  logic [3:0] a_q;
  logic [3:0] b_q;
  logic [7:0] e_q;
  logic [ncd_pkg::PTR_W-1:0] ptr_q;
  logic carry_q;
  logic skip_q;
  logic [PC_WIDTH-1:0] pc_q;
  logic [ncd_pkg::ZW-1:0] z_q;
  logic [ncd_pkg::XW-1:0] x_q;
  logic [ncd_pkg::YW-1:0] y_q;
  logic [ncd_pkg::SP_W-1:0] sp_q;
  logic [PC_WIDTH-1:0] stack_q [ncd_pkg::STACK_DEPTH];
  ncd_pkg::ncd_save_t save_q;
  logic [ncd_pkg::PORTD_W-1:0] portd_q;
  logic [3:0] wdata_q;
  logic we_q;
  logic [6:0] taddr_q;

  // Four-bit add with carry out
  function automatic logic [4:0] add5(input logic [3:0] x, input logic [3:0] y,
                                      input logic ci);
    add5 = {1'b0, x} + {1'b0, y} + {4'h0, ci};
  endfunction

  // Decode of the current instruction
  ncd_pkg::ncd_op_t op;
  wire exec = tick_q & ~skip_q;
  wire [4:0] sum_imm = add5(a_q, INSTR.imm, 1'b0);
  wire [4:0] sum_mem = add5(a_q, RAM_RDATA, 1'b0);
  wire [4:0] sum_cy = add5(a_q, RAM_RDATA, carry_q);
  wire [3:0] bit_mask = 4'h1 << INSTR.bit_sel;
  wire [6:0] in_page_next = pc_q[6:0] + 7'h01;
  wire page_carry = (pc_q[6:0] == ncd_pkg::IN_PAGE_LAST);
  localparam int PAGE_LO_W = ncd_pkg::PAGE_LO;
  wire [PC_WIDTH-PAGE_LO_W-1:0] page_next = pc_q[PC_WIDTH-1:7] + {{(PC_WIDTH-8){1'b0}}, page_carry};
  wire [PC_WIDTH-1:0] pc_inc = {page_next, in_page_next};
  wire [6:0] in_page_idx = {ptr_q, a_q};
  wire [PC_WIDTH-1:0] pc_idx = {pc_q[PC_WIDTH-1:7], in_page_idx};
  wire [ncd_pkg::SP_W-1:0] sp_top = sp_q - 3'h1;
  wire is_push = (op == ncd_pkg::OP_CALL) | (op == ncd_pkg::OP_INDEXED_CALL) |
                 (op == ncd_pkg::OP_TABLE_LOOKUP) | (op == ncd_pkg::OP_INT_ENTRY);
  wire is_pop = (op == ncd_pkg::OP_RETURN) | (op == ncd_pkg::OP_INT_RETURN);
  wire cmp_skip = (op == ncd_pkg::OP_CMP_MEM) & (a_q == RAM_RDATA);
  wire bit_skip = (op == ncd_pkg::OP_BIT_TEST) & ~|(RAM_RDATA & bit_mask);
  assign op = INSTR.op;

  // Instruction clock divider, one tick per three system clocks
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      div_q <= 2'h0;
      tick_q <= 1'b0;
    end else begin
      div_q <= (div_q == ncd_pkg::DIV_LAST) ? 2'h0 : div_q + 2'h1;
      tick_q <= (div_q == ncd_pkg::DIV_LAST);
    end
  end

  // Accumulator, B, E, pointer register
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      a_q <= ncd_pkg::NIB_RST;
      b_q <= ncd_pkg::NIB_RST;
      e_q <= 8'h00;
      ptr_q <= 3'h0;
    end else if (exec) begin
      case (op)
        ncd_pkg::OP_ADD_IMM: a_q <= sum_imm[3:0];
        ncd_pkg::OP_ADD_MEM: a_q <= sum_mem[3:0];
        ncd_pkg::OP_ADD_WITH_CARRY: a_q <= sum_cy[3:0];
        ncd_pkg::OP_AND_MEM: a_q <= a_q & RAM_RDATA;
        ncd_pkg::OP_OR_MEM: a_q <= a_q | RAM_RDATA;
        ncd_pkg::OP_ROTATE_RIGHT: a_q <= {carry_q, a_q[3:1]};
        ncd_pkg::OP_LOAD_A: a_q <= INSTR.imm;
        ncd_pkg::OP_LOAD_B: b_q <= INSTR.imm;
        ncd_pkg::OP_LOAD_PTR: ptr_q <= INSTR.imm[2:0];
        ncd_pkg::OP_PAIR_TO_E: e_q <= {b_q, a_q};
        ncd_pkg::OP_E_TO_PAIR: begin
          b_q <= e_q[7:4];
          a_q <= e_q[3:0];
        end
        ncd_pkg::OP_STACK_INDEX_READ: a_q <= {1'b0, sp_q};
        ncd_pkg::OP_TABLE_LOOKUP: begin
          b_q <= ROM_DATA[7:4];
          a_q <= ROM_DATA[3:0];
        end
        ncd_pkg::OP_INT_RETURN: begin
          a_q <= save_q.a;
          b_q <= save_q.b;
        end
        default: a_q <= a_q;
      endcase
    end
  end

  // Carry flag
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      carry_q <= 1'b0;
    end else if (exec) begin
      case (op)
        ncd_pkg::OP_ADD_WITH_CARRY: carry_q <= sum_cy[4];
        ncd_pkg::OP_ROTATE_RIGHT: carry_q <= a_q[0];
        ncd_pkg::OP_CARRY_SET: carry_q <= 1'b1;
        ncd_pkg::OP_CARRY_CLR: carry_q <= 1'b0;
        ncd_pkg::OP_INT_RETURN: carry_q <= save_q.carry;
        default: carry_q <= carry_q; // Plain adds keep carry
      endcase
    end
  end

  // Skip flag: set by tests, cleared after the skipped slot
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      skip_q <= 1'b0;
    end else if (tick_q) begin
      if (skip_q && op != ncd_pkg::OP_INT_ENTRY) begin
        skip_q <= 1'b0;
      end else if (op == ncd_pkg::OP_INT_ENTRY) begin
        skip_q <= 1'b0; // Pending skip kept in save stage
      end else if (op == ncd_pkg::OP_INT_RETURN) begin
        skip_q <= save_q.skip;
      end else begin
        skip_q <= SKIP_REQ | cmp_skip | bit_skip;
      end
    end
  end

  // RAM pointer and RAM write
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      z_q <= '0;
      x_q <= '0;
      y_q <= '0;
      we_q <= 1'b0;
      wdata_q <= 4'h0;
    end else begin
      we_q <= exec & ((op == ncd_pkg::OP_BIT_SET) | (op == ncd_pkg::OP_BIT_CLR));
      wdata_q <= (op == ncd_pkg::OP_BIT_SET) ? (RAM_RDATA | bit_mask) : (RAM_RDATA & ~bit_mask);
      if (exec) begin
        case (op)
          ncd_pkg::OP_LOAD_PTR_Z: z_q <= INSTR.imm[1:0];
          ncd_pkg::OP_LOAD_PTR_X: x_q <= INSTR.imm[2:0];
          ncd_pkg::OP_LOAD_PTR_Y: y_q <= INSTR.imm;
          ncd_pkg::OP_INT_RETURN: begin
            z_q <= save_q.z;
            x_q <= save_q.x;
            y_q <= save_q.y;
          end
          default: y_q <= y_q;
        endcase
      end
    end
  end

  // Port D bit set and clear at digit selector
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      portd_q <= '0;
    end else if (exec && y_q < 4'(ncd_pkg::PORTD_W)) begin
      if (op == ncd_pkg::OP_PORT_BIT_SET) portd_q[y_q] <= 1'b1;
      else if (op == ncd_pkg::OP_PORT_BIT_CLR) portd_q[y_q] <= 1'b0;
    end
  end

  // Interrupt save stage, written only on interrupt entry
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      save_q <= '0;
    end else if (tick_q && op == ncd_pkg::OP_INT_ENTRY) begin
      save_q <= '{z: z_q, x: x_q, y: y_q, carry: carry_q, skip: skip_q,
                  a: a_q, b: b_q};
    end
  end

  // Return stack and index; overflow just wraps
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sp_q <= '0;
    end else if ((exec && op != ncd_pkg::OP_INT_ENTRY) || (tick_q && op == ncd_pkg::OP_INT_ENTRY)) begin
      // A lookup borrows the top slot and gives it back in the same instruction
      if (is_push && op != ncd_pkg::OP_TABLE_LOOKUP) sp_q <= sp_q + 3'h1;
      else if (is_pop) sp_q <= sp_top;
    end
  end

  // Stack storage has no reset; contents are software-defined
  always_ff @(posedge CLK) begin
    if ((exec || (tick_q && op == ncd_pkg::OP_INT_ENTRY)) && is_push) begin
      stack_q[sp_q] <= (op == ncd_pkg::OP_INT_ENTRY) ? pc_q : pc_inc;
    end
  end

  // Table address follows pointer and accumulator so ROM data is ready at the tick
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      taddr_q <= 7'h00;
    end else begin
      taddr_q <= in_page_idx;
    end
  end

  // Program counter
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pc_q <= ncd_pkg::PC_RST;
    end else if (tick_q) begin
      if (op == ncd_pkg::OP_INT_ENTRY) begin
        pc_q <= INT_VECTOR;
      end else if (!exec) begin
        pc_q <= pc_inc; // Skipped slot still advances
      end else begin
        case (op)
          ncd_pkg::OP_JUMP, ncd_pkg::OP_CALL: pc_q <= INSTR.target;
          ncd_pkg::OP_INDEXED_JUMP, ncd_pkg::OP_INDEXED_CALL: pc_q <= pc_idx;
          ncd_pkg::OP_RETURN, ncd_pkg::OP_INT_RETURN: pc_q <= stack_q[sp_top];
          default: pc_q <= pc_inc;
        endcase
      end
    end
  end

  // Outputs straight from flip-flops
  assign PC = pc_q;
  assign TABLE_ADDR = taddr_q;
  assign RAM_Z = z_q;
  assign RAM_X = x_q;
  assign RAM_Y = y_q;
  assign RAM_WDATA = wdata_q;
  assign RAM_WE = we_q;
  assign ACC = a_q;
  assign REG_B = b_q;
  assign REG_E = e_q;
  assign CARRY_FLAG = carry_q;
  assign SKIP_FLAG = skip_q;
  assign STACK_INDEX = sp_q;
  assign INSTR_TICK = tick_q;
  assign PORT_D = portd_q;

  // Tick every third cycle
  a_tick_period: assert property (@(posedge CLK) disable iff (!RST_N)
    tick_q |=> !tick_q ##1 !tick_q ##1 tick_q) else $error("tick period wrong");
  // Carry from add-with-carry
  a_carry_add: assert property (@(posedge CLK) disable iff (!RST_N)
    exec && op == ncd_pkg::OP_ADD_WITH_CARRY |=> carry_q == $past(sum_cy[4]))
    else $error("carry not from sum");
  // Plain adds keep carry
  a_carry_keep: assert property (@(posedge CLK) disable iff (!RST_N)
    exec && (op == ncd_pkg::OP_ADD_IMM || op == ncd_pkg::OP_ADD_MEM) |=> $stable(carry_q))
    else $error("carry changed by add");
  // Rotate takes bit zero
  a_rotate_carry: assert property (@(posedge CLK) disable iff (!RST_N)
    exec && op == ncd_pkg::OP_ROTATE_RIGHT |=> carry_q == $past(a_q[0]))
    else $error("rotate carry wrong");
  // Carry set op
  a_carry_set: assert property (@(posedge CLK) disable iff (!RST_N)
    exec && op == ncd_pkg::OP_CARRY_SET |=> carry_q) else $error("carry not set");
  // Call advances index
  a_push_index: assert property (@(posedge CLK) disable iff (!RST_N)
    exec && (op == ncd_pkg::OP_CALL) |=> sp_q == $past(sp_q) + 3'h1)
    else $error("index not advanced");
  // Save stage holds outside interrupt entry
  a_save_hold: assert property (@(posedge CLK) disable iff (!RST_N)
    !(tick_q && op == ncd_pkg::OP_INT_ENTRY) |=> $stable(save_q))
    else $error("save stage disturbed");
  // In-page wrap
  a_page_wrap: assert property (@(posedge CLK) disable iff (!RST_N)
    tick_q && op == ncd_pkg::OP_NOP && pc_q[6:0] == 7'h7F |=> pc_q[6:0] == 7'h00 &&
    pc_q[PC_WIDTH-1:7] == $past(pc_q[PC_WIDTH-1:7]) + 1'b1) else $error("page wrap wrong");
  // Skipped slot changes no accumulator
  a_skip_nop: assert property (@(posedge CLK) disable iff (!RST_N)
    tick_q && skip_q && op == ncd_pkg::OP_LOAD_A |=> $stable(a_q) && !skip_q)
    else $error("skipped op executed");
  c_call: cover property (@(posedge CLK) exec && op == ncd_pkg::OP_CALL);
  c_int: cover property (@(posedge CLK) tick_q && op == ncd_pkg::OP_INT_ENTRY);
  c_skip: cover property (@(posedge CLK) tick_q && skip_q);
endmodule // ncd_core

// [sim/ncd_mem_model.sv]
// Behavioural program ROM and data RAM that face the core
`timescale 1ns/1ps
module ncd_mem_model (
  // Clock
  input wire logic clk,
  // RAM pointer and write side
  input wire logic [1:0] ram_z,
  input wire logic [2:0] ram_x,
  input wire logic [3:0] ram_y,
  input wire logic [3:0] ram_wdata,
  input wire logic ram_we,
  // Table address from the core
  input wire logic [6:0] table_addr,
  // Read data back to the core
  output logic [3:0] ram_rdata,
  output logic [9:0] rom_data
);
  // Word array; every word starts at a known pattern
  logic [3:0] mem_q [512];
  // Word index from group, file and digit selectors
  wire [8:0] word_idx = {ram_z, ram_x, ram_y};
  // Fill so that the bench can predict every read
  initial begin
    foreach (mem_q[i]) mem_q[i] = 4'h9;
  end
  // Store the addressed word on the write pulse
  always @(posedge clk) begin
    if (ram_we) begin
      mem_q[word_idx] <= ram_wdata;
    end
  end
  // Read follows the pointer with no wait
  assign ram_rdata = mem_q[word_idx];
  // Table word depends on the in-page address
  assign rom_data = 10'h280 | {3'h0, table_addr};
endmodule // ncd_mem_model

// [sim/testbench.sv]
// Self-checking bench for the nibble core datapath
`timescale 1ns/1ps
module testbench;
  // Stimulus
  logic clk, rst_n, skip_req;
  ncd_pkg::ncd_instr_t instr;
  logic [13:0] int_vector, pc, epc;
  // Observed outputs
  logic [6:0] table_addr;
  logic [1:0] ram_z;
  logic [2:0] ram_x, sidx, s0;
  logic [3:0] ram_y, ram_wdata, ram_rdata, acc, reg_b;
  logic [9:0] rom_data, port_d;
  logic [7:0] reg_e;
  logic ram_we, carry, skip, tick;
  int bad_count, compares, n;
  // One row: operation, immediate, accumulator and carry it leaves
  typedef struct packed {
    ncd_pkg::ncd_op_t op; logic [3:0] imm; logic [3:0] acc; logic cy;
  } ncd_row_t;
  ncd_row_t rows [13] = '{
    '{ncd_pkg::OP_LOAD_A, 4'h7, 4'h7, 1'b0}, '{ncd_pkg::OP_CARRY_SET, 4'h0, 4'h7, 1'b1},
    '{ncd_pkg::OP_ADD_IMM, 4'hC, 4'h3, 1'b1}, '{ncd_pkg::OP_CARRY_CLR, 4'h0, 4'h3, 1'b0},
    '{ncd_pkg::OP_ADD_MEM, 4'h0, 4'hC, 1'b0}, '{ncd_pkg::OP_ADD_WITH_CARRY, 4'h0, 4'h5, 1'b1},
    '{ncd_pkg::OP_ADD_WITH_CARRY, 4'h0, 4'hF, 1'b0},
    '{ncd_pkg::OP_ROTATE_RIGHT, 4'h0, 4'h7, 1'b1}, '{ncd_pkg::OP_AND_MEM, 4'h0, 4'h1, 1'b1},
    '{ncd_pkg::OP_OR_MEM, 4'h0, 4'h9, 1'b1}, '{ncd_pkg::OP_ROTATE_RIGHT, 4'h0, 4'hC, 1'b1},
    '{ncd_pkg::OP_ADD_IMM, 4'hF, 4'hB, 1'b1}, '{ncd_pkg::OP_CMP_MEM, 4'h0, 4'hB, 1'b1}};
  // Device under test
  ncd_core u_dut (
    .CLK(clk), .RST_N(rst_n), .INSTR(instr), .ROM_DATA(rom_data),
    .RAM_RDATA(ram_rdata), .SKIP_REQ(skip_req), .INT_VECTOR(int_vector),
    .PC(pc), .TABLE_ADDR(table_addr), .RAM_Z(ram_z), .RAM_X(ram_x), .RAM_Y(ram_y),
    .RAM_WDATA(ram_wdata), .RAM_WE(ram_we), .ACC(acc), .REG_B(reg_b), .REG_E(reg_e),
    .CARRY_FLAG(carry), .SKIP_FLAG(skip), .STACK_INDEX(sidx), .INSTR_TICK(tick),
    .PORT_D(port_d)
  );
  // Far side memories
  ncd_mem_model u_mem (
    .clk(clk), .ram_z(ram_z), .ram_x(ram_x), .ram_y(ram_y), .ram_wdata(ram_wdata),
    .ram_we(ram_we), .table_addr(table_addr), .ram_rdata(ram_rdata), .rom_data(rom_data)
  );
  // Compare a value and count the outcome
  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Compare a single flag
  task automatic chkf(input logic got, input logic exp);
    chk({13'h0000, got}, {13'h0000, exp});
  endtask
  // Count falling edges until the tick is seen, bounded
  task automatic wait_tick();
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (tick !== 1'b1 && n < 8);
  endtask
  // Hand one instruction over; return once its results have settled
  task automatic run(input ncd_pkg::ncd_op_t op, input logic [3:0] imm, input logic [13:0] tgt);
    @(posedge clk);
    instr <= '{op: op, imm: imm, bit_sel: imm[1:0], target: tgt};
    wait_tick();
    chkf(n < 8, 1'b1);
    @(posedge clk);
    @(negedge clk);
    epc = epc + 14'h0001;
  endtask
  // Print the counts and the verdict, then stop
  task automatic give_verdict();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Clock of 5 ns
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Cut a hang short
  initial begin
    #50000;
    bad_count++;
    give_verdict();
  end
  // Main sequence
  initial begin
    rst_n = 1'b0;
    skip_req = 1'b0;
    instr = '0;
    int_vector = 14'h0080;
    epc = 14'h0000;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(pc, 14'h0000);
    chk({10'h000, acc}, 14'h0000);
    @(posedge clk);
    rst_n <= 1'b1;
    wait_tick();
    wait_tick();
    chk(14'(n), 14'h0003);
    // Two idle ticks have each run a no-operation before the first row
    epc = 14'h0002;
    for (int i = 0; i < 13; i++) begin
      run(rows[i].op, rows[i].imm, 14'h0000);
      chk({10'h000, acc}, {10'h000, rows[i].acc});
      chkf(carry, rows[i].cy);
      chk(pc, epc);
    end
    chkf(skip, 1'b0);
    // Pair view in both directions
    run(ncd_pkg::OP_LOAD_B, 4'hA, 14'h0000);
    run(ncd_pkg::OP_LOAD_A, 4'h5, 14'h0000);
    run(ncd_pkg::OP_PAIR_TO_E, 4'h0, 14'h0000);
    chk({6'h00, reg_e}, 14'h00A5);
    run(ncd_pkg::OP_LOAD_A, 4'h0, 14'h0000);
    run(ncd_pkg::OP_LOAD_B, 4'h0, 14'h0000);
    run(ncd_pkg::OP_E_TO_PAIR, 4'h0, 14'h0000);
    chk({6'h00, reg_b, acc}, 14'h00A5);
    // Table address from pointer and accumulator
    run(ncd_pkg::OP_LOAD_PTR, 4'h3, 14'h0000);
    run(ncd_pkg::OP_LOAD_A, 4'h6, 14'h0000);
    run(ncd_pkg::OP_TABLE_LOOKUP, 4'h0, 14'h0000);
    chk({7'h00, table_addr}, 14'h0036);
    chk({6'h00, reg_b, acc}, 14'h00B6);
    // Last in-page address rolls into the next page
    run(ncd_pkg::OP_JUMP, 4'h0, 14'h007F);
    chk(pc, 14'h007F);
    run(ncd_pkg::OP_NOP, 4'h0, 14'h0000);
    chk(pc, 14'h0080);
    // Call, index read and return
    s0 = sidx;
    run(ncd_pkg::OP_CALL, 4'h0, 14'h0123);
    chk(pc, 14'h0123);
    chk({11'h000, sidx}, {11'h000, 3'(s0 + 3'h1)});
    run(ncd_pkg::OP_STACK_INDEX_READ, 4'h0, 14'h0000);
    chk({10'h000, acc}, {11'h000, 3'(s0 + 3'h1)});
    run(ncd_pkg::OP_RETURN, 4'h0, 14'h0000);
    chk(pc, 14'h0081);
    // Nine nested calls wrap the index silently
    for (int i = 0; i < 9; i++) run(ncd_pkg::OP_CALL, 4'h0, 14'h0200);
    chk({11'h000, sidx}, {11'h000, 3'(s0 + 3'h1)});
    for (int i = 0; i < 9; i++) run(ncd_pkg::OP_RETURN, 4'h0, 14'h0000);
    chk({11'h000, sidx}, {11'h000, s0});
    // Interrupt save and restore around a call and a lookup
    run(ncd_pkg::OP_LOAD_PTR_Z, 4'h1, 14'h0000);
    run(ncd_pkg::OP_LOAD_PTR_X, 4'h2, 14'h0000);
    run(ncd_pkg::OP_LOAD_PTR_Y, 4'h3, 14'h0000);
    chk({5'h00, ram_z, ram_x, ram_y}, 14'h00A3);
    run(ncd_pkg::OP_CARRY_SET, 4'h0, 14'h0000);
    run(ncd_pkg::OP_LOAD_A, 4'h4, 14'h0000);
    run(ncd_pkg::OP_LOAD_B, 4'h6, 14'h0000);
    run(ncd_pkg::OP_INT_ENTRY, 4'h0, 14'h0000);
    chk(pc, 14'h0080);
    run(ncd_pkg::OP_LOAD_A, 4'hF, 14'h0000);
    run(ncd_pkg::OP_LOAD_B, 4'h0, 14'h0000);
    run(ncd_pkg::OP_CARRY_CLR, 4'h0, 14'h0000);
    run(ncd_pkg::OP_LOAD_PTR_Y, 4'h7, 14'h0000);
    run(ncd_pkg::OP_CALL, 4'h0, 14'h0300);
    run(ncd_pkg::OP_TABLE_LOOKUP, 4'h0, 14'h0000);
    run(ncd_pkg::OP_RETURN, 4'h0, 14'h0000);
    run(ncd_pkg::OP_INT_RETURN, 4'h0, 14'h0000);
    chk({6'h00, reg_b, acc}, 14'h0064);
    chk({9'h000, carry, ram_y}, 14'h0013);
    chk({11'h000, sidx}, {11'h000, s0});
    // Equal compare sets skip; the next instruction does nothing
    run(ncd_pkg::OP_JUMP, 4'h0, 14'h0010);
    epc = 14'h0010;
    run(ncd_pkg::OP_LOAD_A, 4'h9, 14'h0000);
    run(ncd_pkg::OP_CMP_MEM, 4'h0, 14'h0000);
    chkf(skip, 1'b1);
    run(ncd_pkg::OP_LOAD_A, 4'h2, 14'h0000);
    chk({9'h000, skip, acc}, 14'h0009);
    chk(pc, epc);
    // Bit clear writes the RAM word back; read it again
    run(ncd_pkg::OP_BIT_CLR, 4'h0, 14'h0000);
    chk({9'h000, ram_we, ram_wdata}, 14'h0018);
    run(ncd_pkg::OP_LOAD_A, 4'hF, 14'h0000);
    run(ncd_pkg::OP_AND_MEM, 4'h0, 14'h0000);
    chk({10'h000, acc}, 14'h0008);
    run(ncd_pkg::OP_BIT_TEST, 4'h1, 14'h0000);
    chkf(skip, 1'b1);
    run(ncd_pkg::OP_NOP, 4'h0, 14'h0000);
    // Port bits picked by the digit selector; out of range ignored
    run(ncd_pkg::OP_LOAD_PTR_Y, 4'h3, 14'h0000);
    run(ncd_pkg::OP_PORT_BIT_SET, 4'h0, 14'h0000);
    chk({4'h0, port_d}, 14'h0008);
    run(ncd_pkg::OP_LOAD_PTR_Y, 4'h9, 14'h0000);
    run(ncd_pkg::OP_PORT_BIT_SET, 4'h0, 14'h0000);
    run(ncd_pkg::OP_LOAD_PTR_Y, 4'h3, 14'h0000);
    run(ncd_pkg::OP_PORT_BIT_CLR, 4'h0, 14'h0000);
    run(ncd_pkg::OP_LOAD_PTR_Y, 4'hC, 14'h0000);
    run(ncd_pkg::OP_PORT_BIT_SET, 4'h0, 14'h0000);
    chk({4'h0, port_d}, 14'h0200);
    // External skip request taken at the tick; next instruction does nothing
    @(posedge clk);
    skip_req <= 1'b1;
    run(ncd_pkg::OP_NOP, 4'h0, 14'h0000);
    chkf(skip, 1'b1);
    @(posedge clk);
    skip_req <= 1'b0;
    run(ncd_pkg::OP_LOAD_A, 4'h5, 14'h0000);
    chk({9'h000, skip, acc}, 14'h0008);
    give_verdict();
  end
endmodule // testbench
